// ===== hw/tmev_defines.vh
// Register offsets, field positions, reset values and timing constants of the timer/event counter.
`ifndef TMEV_DEFINES_VH
`define TMEV_DEFINES_VH
// Register offsets on the plain register port.
`define TMEV_ADDR_COUNT 2'h0
`define TMEV_ADDR_COMPARE 2'h1
`define TMEV_ADDR_CLKSEL 2'h2
`define TMEV_ADDR_MODE 2'h3
// Mode control register field positions.
`define TMEV_MODE_ENABLE 7
`define TMEV_MODE_PWM 6
`define TMEV_MODE_LVSET 3
`define TMEV_MODE_LVCLR 2
`define TMEV_MODE_INVPOL 1
`define TMEV_MODE_DRIVE 0
// Writable bits of the mode control register; bits 5 and 4 are fixed zero.
`define TMEV_MODE_MASK 8'hcf
// Reset values.
`define TMEV_RST_BYTE 8'h00
`define TMEV_RST_CLKSEL 3'h0
// Clock select codes.
`define TMEV_CKS_PIN_FALL 3'h0
`define TMEV_CKS_PIN_RISE 3'h1
`define TMEV_CKS_DIV1 3'h2
`define TMEV_CKS_DIV2 3'h3
`define TMEV_CKS_DIV4 3'h4
`define TMEV_CKS_DIV64 3'h5
`define TMEV_CKS_DIV256 3'h6
`define TMEV_CKS_DIV8192 3'h7
// Width of the free-running prescaler.
`define TMEV_PRE_W 13
// Top count at which the counter wraps in PWM mode.
`define TMEV_COUNT_TOP 8'hff
`endif

// ===== hw/tmev_timer.v
// Eight-bit timer/event counter with compare, square-wave and PWM output.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "tmev_defines.vh"
module tmev_timer (
   // Clock and asynchronous active-high reset.
   input wire i_clk,
   input wire i_rst,
   // Register port; read data follow the read strobe by one cycle.
   input wire [1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // Far-side pins and the match request.
   input wire i_event_input_pin,
   output reg o_wave_output_pin,
   output reg o_match_irq
);

   // Prescaler, count source and register state.
   reg [`TMEV_PRE_W-1:0] pre_r; // Free-running prescaler of the system clock.
   reg [`TMEV_PRE_W-1:0] pre_nxt; // Next prescaler value.
   reg pin_s1_r; // First synchroniser stage of the event pin.
   reg pin_s2_r; // Second synchroniser stage of the event pin.
   reg pin_d_r; // Delayed synchronised pin for edge detection.
   reg [2:0] clock_select_field_r; // Count source selection.
   reg [7:0] mode_control_reg_r; // Mode bits; level bits are never stored.
   reg [7:0] compare_value_r; // Compare value that governs matches.
   reg [7:0] compare_buf_r; // Value written by software, shown on reads.
   reg buf_pend_r; // A buffered PWM compare value awaits transfer.
   reg buf_late_r; // The write came after the FFH count edge.
   reg [7:0] count_value_r; // The counter itself.
   reg tff_r; // Timer output flip-flop.
   reg pwm_act_r; // PWM phase: high while in the active part of the cycle.

   // Mode bits pulled out for readability.
   // Bits 5 and 4 are never stored, so they need no decode of their own.
   wire cnt_en = mode_control_reg_r[`TMEV_MODE_ENABLE];
   wire pwm_sel = mode_control_reg_r[`TMEV_MODE_PWM];
   wire inv_pol = mode_control_reg_r[`TMEV_MODE_INVPOL];
   wire drive_en = mode_control_reg_r[`TMEV_MODE_DRIVE];

   // Write decode: one place so every register sees the same strobe.
   // Reads have no side effects, so only writes are decoded here.
   wire wr_mode = i_wr && (i_addr == `TMEV_ADDR_MODE);
   wire wr_cmp = i_wr && (i_addr == `TMEV_ADDR_COMPARE);
   wire wr_cks = i_wr && (i_addr == `TMEV_ADDR_CLKSEL);

   // Returns the one-cycle pulse of a prescaler tap: set when all bits below the tap are ones.
   // Each tap fires once in every 2^bits cycles, so the divided rates are exact.
   function tap_pulse;
      input [`TMEV_PRE_W-1:0] pre;
      input [3:0] bits;
      reg [`TMEV_PRE_W-1:0] mask;
      begin
         mask = ({`TMEV_PRE_W{1'b1}} >> (`TMEV_PRE_W - bits));
         tap_pulse = ((pre & mask) == mask);
      end
   endfunction

   // Next count value; the carry out of bit 7 is dropped on purpose,
   // so FFH wraps to 00H.
   function [7:0] next_count;
      input [7:0] cnt;
      begin
         next_count = cnt + 8'h01;
      end
   endfunction

   // Count clock enable from the selected source.
   reg count_tick; // One-cycle count clock pulse.
   wire pin_rise = pin_s2_r && !pin_d_r; // Rising edge of the synchronised pin.
   wire pin_fall = !pin_s2_r && pin_d_r; // Falling edge of the synchronised pin.
   always @* begin
      case (clock_select_field_r)
         `TMEV_CKS_PIN_FALL: begin
            count_tick = pin_fall;
         end
         `TMEV_CKS_PIN_RISE: begin
            count_tick = pin_rise;
         end
         `TMEV_CKS_DIV1: begin
            count_tick = 1'b1;
         end
         `TMEV_CKS_DIV2: begin
            count_tick = tap_pulse(pre_r, 4'h1);
         end
         `TMEV_CKS_DIV4: begin
            count_tick = tap_pulse(pre_r, 4'h2);
         end
         `TMEV_CKS_DIV64: begin
            count_tick = tap_pulse(pre_r, 4'h6);
         end
         `TMEV_CKS_DIV256: begin
            count_tick = tap_pulse(pre_r, 4'h8);
         end
         default: begin
            // Code 7: the slowest tap of the prescaler.
            count_tick = tap_pulse(pre_r, 4'hd);
         end
      endcase
   end

   // The prescaler runs free, so a start lands anywhere in a count period.
   // It wraps every 8192 cycles, which is exactly the slowest tap.
   always @* begin
      pre_nxt = pre_r + {{(`TMEV_PRE_W-1){1'b0}}, 1'b1};
   end

   // Match and overflow events, both qualified by the count clock.
   // A match needs a tick, so a slow count clock cannot raise it twice.
   wire adv = cnt_en && count_tick;
   wire match = adv && (count_value_r == compare_value_r);
   wire ovf = adv && pwm_sel && (count_value_r == `TMEV_COUNT_TOP);
   // PWM active phase ends at the tick that brings the counter to the compare value.
   wire pwm_clr = adv && pwm_sel && (next_count(count_value_r) == compare_value_r);
   // Compare value that governs the period starting at this overflow.
   wire [7:0] cmp_next = (buf_pend_r && !buf_late_r) ? compare_buf_r : compare_value_r;

   // Event pin synchroniser; only the second stage feeds logic.
   // The delayed copy adds a cycle of latency but keeps edges off the first stage.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_d_r <= 1'b0;
         pre_r <= {`TMEV_PRE_W{1'b0}};
      end else begin
         pin_s1_r <= i_event_input_pin;
         pin_s2_r <= pin_s1_r;
         pin_d_r <= pin_s2_r;
         pre_r <= pre_nxt;
      end
   end

   // Control registers. Level bits act at write time and are not stored.
   // Trade-off: a level write takes effect at once, so it cannot be queued.
   // Software must therefore preset the level while the counter is stopped.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_control_reg_r <= `TMEV_RST_BYTE;
         clock_select_field_r <= `TMEV_RST_CLKSEL;
      end else begin
         if (wr_mode) begin
            mode_control_reg_r <= i_wdata & `TMEV_MODE_MASK & 8'hf3;
         end
         if (wr_cks) begin
            clock_select_field_r <= i_wdata[2:0];
         end
      end
   end

   // Compare register with the PWM reload buffer.
   // Reads always show the last write, even while a reload is still pending.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         compare_value_r <= `TMEV_RST_BYTE;
         compare_buf_r <= `TMEV_RST_BYTE;
         buf_pend_r <= 1'b0;
         buf_late_r <= 1'b0;
      end else begin
         if (wr_cmp) begin
            compare_buf_r <= i_wdata;
         end
         if (wr_cmp && !(pwm_sel && cnt_en)) begin
            // Outside running PWM the value applies at once.
            compare_value_r <= i_wdata;
            buf_pend_r <= 1'b0;
            buf_late_r <= 1'b0;
         end else if (wr_cmp) begin
            // A write after the FFH edge has been counted waits one more overflow.
            buf_pend_r <= 1'b1;
            buf_late_r <= (count_value_r == `TMEV_COUNT_TOP) || ovf;
         end else if (ovf && buf_pend_r) begin
            if (buf_late_r) begin
               buf_late_r <= 1'b0;
            end else begin
               compare_value_r <= compare_buf_r;
               buf_pend_r <= 1'b0;
            end
         end
      end
   end

   // Counter: clears on match in clear-and-start mode, wraps in PWM mode.
   // Stopping clears it, so every start counts from zero.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count_value_r <= `TMEV_RST_BYTE;
      end else if (!cnt_en) begin
         count_value_r <= `TMEV_RST_BYTE;
      end else if (adv) begin
         if (match && !pwm_sel) begin
            count_value_r <= `TMEV_RST_BYTE;
         end else begin
            count_value_r <= next_count(count_value_r);
         end
      end
   end

   // Output flip-flop and PWM phase.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tff_r <= 1'b0;
         pwm_act_r <= 1'b0;
      end else begin
         if (wr_mode && !i_wdata[`TMEV_MODE_PWM]) begin
            // Pattern 11 is prohibited and leaves the flip-flop alone.
            case ({i_wdata[`TMEV_MODE_LVSET], i_wdata[`TMEV_MODE_LVCLR]})
               2'b01: begin
                  tff_r <= 1'b0;
               end
               2'b10: begin
                  tff_r <= 1'b1;
               end
               default: begin
                  tff_r <= tff_r;
               end
            endcase
         end else if (!pwm_sel && inv_pol && match) begin
            tff_r <= ~tff_r;
         end
         // Stopping forces the inactive phase; polarity is applied only at the pin.
         if (!cnt_en || !pwm_sel) begin
            pwm_act_r <= 1'b0;
         end else if (ovf) begin
            // Compare zero gives no active part at all.
            pwm_act_r <= (cmp_next != 8'h00);
         end else if (pwm_clr) begin
            pwm_act_r <= 1'b0;
         end
      end
   end

   // Output pin, irq pulse and read data, all from flip-flops.
   // The pin lags its source by one cycle in every mode, so widths stay exact.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wave_output_pin <= 1'b0;
         o_match_irq <= 1'b0;
         o_rdata <= `TMEV_RST_BYTE;
      end else begin
         // One pulse per match, since a match needs a count tick.
         o_match_irq <= match;
         if (!drive_en) begin
            o_wave_output_pin <= 1'b0;
         end else if (pwm_sel) begin
            o_wave_output_pin <= pwm_act_r ^ inv_pol;
         end else begin
            o_wave_output_pin <= tff_r;
         end
         // Idle cycles return zero, so stale data never looks like a fresh read.
         if (i_rd) begin
            case (i_addr)
               `TMEV_ADDR_COUNT: begin
                  o_rdata <= count_value_r;
               end
               `TMEV_ADDR_COMPARE: begin
                  o_rdata <= compare_buf_r;
               end
               `TMEV_ADDR_CLKSEL: begin
                  o_rdata <= {5'h00, clock_select_field_r};
               end
               default: begin
                  o_rdata <= mode_control_reg_r;
               end
            endcase
         end else begin
            o_rdata <= `TMEV_RST_BYTE;
         end
      end
   end

endmodule

// ===== sim/tmev_timer_properties.sv
// Port checker for the timer and its bind.
`timescale 1ns/1ps
module tmev_chk (
   input wire i_clk,
   input wire i_rst,
   input wire [1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   input wire i_event_input_pin,
   input wire o_wave_output_pin,
   input wire o_match_irq
);
   reg [7:0] mode_r, cmp_r; // Shadows of the mode and compare writes.
   reg [2:0] cks_r; // Shadow of the count source.
   reg [8:0] gap_r; // Cycles since the last match pulse.
   reg [1:0] seen_r; // Match pulses since the last write, trusted from three on.
   wire sq = mode_r[7:6] == 2'b10 && mode_r[1:0] == 2'b11; // Square wave running.
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Any write restarts the history, because it may move the match point.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         {mode_r, cmp_r, cks_r, gap_r, seen_r} <= 30'h0;
      end else begin
         gap_r <= o_match_irq ? 9'h001 : gap_r + {8'h00, gap_r != 9'h1ff};
         if (i_wr) begin
            seen_r <= 2'h0;
            if (i_addr == 2'h1) cmp_r <= i_wdata;
            if (i_addr == 2'h2) cks_r <= i_wdata[2:0];
            if (i_addr == 2'h3) mode_r <= i_wdata;
         end else if (o_match_irq && seen_r != 2'h3) begin
            seen_r <= seen_r + 2'h1;
         end
      end
   end
   property p_lvl_rd; $past(i_rd) && $past(i_addr) == 2'h3 |-> o_rdata[5:2] == 4'h0;
   endproperty
   a_lvl_rd: assert property (p_lvl_rd) else $error("mode bits 5 to 2 read set");
   property p_cks_rd; $past(i_rd) && $past(i_addr) == 2'h2 |-> o_rdata[7:3] == 5'h00;
   endproperty
   a_cks_rd: assert property (p_cks_rd) else $error("clock select high bits set");
   property p_out_off; (!mode_r[0]) [*3] |-> !o_wave_output_pin;
   endproperty
   a_out_off: assert property (p_out_off) else $error("output not held low");
   property p_stop_irq; (!mode_r[7]) [*4] |-> !o_match_irq;
   endproperty
   a_stop_irq: assert property (p_stop_irq) else $error("match while stopped");
   property p_interval; o_match_irq && seen_r == 2'h3 && mode_r[7:6] == 2'b10 &&
      cks_r == 3'h2 |-> gap_r == {1'b0, cmp_r} + 9'h001;
   endproperty
   a_interval: assert property (p_interval) else $error("interval spacing wrong");
   property p_pwm_per; o_match_irq && seen_r == 2'h3 && mode_r[7:6] == 2'b11 &&
      cks_r == 3'h2 |-> gap_r == 9'h100;
   endproperty
   a_pwm_per: assert property (p_pwm_per) else $error("pwm period wrong");
   property p_sq_tog; o_match_irq && sq |-> ##[0:2] $changed(o_wave_output_pin);
   endproperty
   a_sq_tog: assert property (p_sq_tog) else $error("square output did not toggle");
   property p_pwm_stop; (mode_r[7:6] == 2'b01 && mode_r[0] && $stable(mode_r)) [*3]
      |-> o_wave_output_pin == mode_r[1];
   endproperty
   a_pwm_stop: assert property (p_pwm_stop) else $error("stopped pwm not inactive");
   c_pwm: cover property (o_match_irq && mode_r[6]);
   c_sq: cover property (sq && $changed(o_wave_output_pin));
   c_evt: cover property (mode_r[7] && cks_r[2:1] == 2'b00 && $rose(i_event_input_pin));
endmodule
bind tmev_timer tmev_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_event_input_pin(i_event_input_pin), .o_wave_output_pin(o_wave_output_pin),
   .o_match_irq(o_match_irq));

// ===== sim/tmev_pulse_src.sv
// Behavioural external pulse source that drives the event input.
`timescale 1ns/1ps
module tmev_pulse_src (
   output reg o_pin
);
   initial o_pin = 1'b0; // Idle low from time zero.
   // Toggles the line n times; 173 ns spacing drifts against the clock phase.
   task automatic toggle(input int n);
      repeat (n) begin
         #173 o_pin = ~o_pin;
      end
   endtask
endmodule

// ===== sim/tmev_timer_tb.sv
// Self-checking bench: registers, interval, events, square wave and PWM.
`timescale 1ns/1ps
module tmev_timer_tb;
   logic i_clk, i_rst, i_wr, i_rd;
   logic [1:0] i_addr;
   logic [7:0] i_wdata, rdata;
   logic [7:0] cmpv [3] = '{8'h01, 8'h04, 8'hff}; // Interval compare values, from 01H up to the top end FFH.
   logic [15:0] divv [5] = '{16'h0004, 16'h0008, 16'h0080, 16'h0200, 16'h4000}; // Codes 3 to 7.
   wire [7:0] o_rdata;
   wire pin, o_wave_output_pin, o_match_irq;
   int n_fail, checks, a, b;
   tmev_timer DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_input_pin(pin),
      .o_wave_output_pin(o_wave_output_pin), .o_match_irq(o_match_irq));
   tmev_pulse_src u_src (.o_pin(pin));
   always #20 i_clk = ~i_clk;
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= ad;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd(input logic [1:0] ad);
      @(posedge i_clk);
      i_addr <= ad;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rdata = o_rdata;
   endtask
   // Both waits are bounded so a dead output shows as a wrong count, not a hang.
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (o_match_irq !== 1'b1 && n < 17000);
   endtask
   task automatic wait_change(output int n);
      logic was;
      was = o_wave_output_pin;
      n = 0;
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (o_wave_output_pin === was && n < 600);
   endtask
   // Syncs to the start of a level, then returns its width and the whole period.
   task automatic pwm_meas(input logic lvl, output int w, output int p);
      int t;
      t = 0;
      do wait_change(w); while (o_wave_output_pin !== lvl && t++ < 4);
      wait_change(w);
      wait_change(p);
      p = p + w;
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #3000000 n_fail++;
      give_verdict();
   end
   initial begin
      i_clk = 1'b0;
      i_rst = 1'b1;
      i_addr = 2'h0;
      i_wdata = 8'h00;
      i_wr = 1'b0;
      i_rd = 1'b0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      wr(3, 8'h7f);
      rd(3);
      check("mode readback", rdata, 8'h43);
      wr(2, 8'hff);
      rd(2);
      check("clock select readback", rdata, 8'h07);
      foreach (cmpv[i]) begin
         wr(3, 8'h00);
         wr(2, 8'h02);
         wr(1, cmpv[i]);
         wr(3, 8'h80);
         repeat (4) wait_irq(b);
         check("interval", b, cmpv[i] + 16'h1);
      end
      // Every divider tap: compare 1 gives two count periods between matches.
      for (a = 3; a < 8; a++) begin
         wr(3, 8'h00);
         wr(2, a[7:0]);
         wr(1, 8'h01);
         wr(3, 8'h80);
         repeat (2) wait_irq(b);
         check("divided interval", b, divv[a - 3]);
      end
      wr(3, 8'h00);
      rd(0);
      check("stopped count", rdata, 8'h00);
      // Code 1 starts low and code 0 starts high, so the chosen edge occurs four times.
      for (a = 0; a < 2; a++) begin
         wr(3, 8'h00);
         wr(2, 8'h01 - a[7:0]);
         wr(1, 8'hff);
         wr(3, 8'h80);
         u_src.toggle(7);
         repeat (8) @(posedge i_clk);
         rd(0);
         check("event count", rdata, 8'h04);
      end
      wr(3, 8'h00);
      wr(2, 8'h02);
      wr(1, 8'h03);
      wr(3, 8'h0b);
      repeat (3) @(posedge i_clk);
      #1 check("preset high", o_wave_output_pin, 1'b1);
      wr(3, 8'h83);
      wait_change(a);
      wait_change(b);
      check("half period", b, 4);
      wr(3, 8'h03);
      wr(3, 8'h07);
      repeat (3) @(posedge i_clk);
      #1 check("preset low", o_wave_output_pin, 1'b0);
      wr(1, 8'h40);
      wr(3, 8'h41);
      wr(3, 8'hc1);
      pwm_meas(1'b1, a, b);
      check("active width", a, 16'h40);
      check("pwm period", b, 256);
      wr(1, 8'h80);
      rd(1);
      check("buffered compare", rdata, 8'h80);
      pwm_meas(1'b1, a, b);
      check("new width", a, 16'h80);
      wr(3, 8'h41);
      wr(3, 8'h43);
      wr(3, 8'hc3);
      pwm_meas(1'b0, a, b);
      check("active low width", a, 16'h80);
      repeat (3) wait_irq(b);
      check("pwm match spacing", b, 256);
      @(posedge i_clk);
      #1 check("irq pulse width", o_match_irq, 1'b0);
      wr(3, 8'h43);
      repeat (4) @(posedge i_clk);
      #1 check("stopped level", o_wave_output_pin, 1'b1);
      give_verdict();
   end
endmodule
